// File: hdl/uflc_pkg.sv
// Constants, register map and carrier types of the flow-controlled serial port.
// Assumes one 40 MHz core clock and an APB register bus with 32-bit data.
package uflc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and bit rate figures.
    localparam int CLK_HZ   = 40_000_000;
    localparam int BAUD_RST = 9600;
    // Eighteen bits hold the divisor of the slowest rate, 183 baud.
    localparam int DIV_W    = 18;
    // A bit lasts at least eight core clocks, so the top rate is a clock over 8.
    localparam logic [DIV_W-1:0] DIV_MIN = 18'h00008;
    localparam int DIV_RST  = (CLK_HZ + BAUD_RST / 2) / BAUD_RST;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the APB bus.
    localparam logic [7:0] A_CFG  = 8'h00;
    localparam logic [7:0] A_DIV  = 8'h04;
    localparam logic [7:0] A_TXD  = 8'h08;
    localparam logic [7:0] A_RXD  = 8'h0c;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [7:0] A_MASK = 8'h14;
    localparam logic [7:0] A_LINE = 8'h18;

    // Event bit positions, shared by the status and mask registers.
    localparam int EV_TXDONE = 0;
    localparam int EV_RXRDY  = 1;
    localparam int EV_FERR   = 2;
    localparam int EV_PERR   = 3;
    localparam int EV_OVR    = 4;
    localparam int EV_RING   = 5;
    localparam int EV_W      = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration word, bit 0 first from the bottom.
    typedef struct packed {
        logic dtr;
        logic ri_wake;
        logic flow;
        logic stop2;
        logic par_odd;
        logic par_en;
        logic data8;
    } uflc_cfg_s;

    // Eight data bits, handshake flow control, terminal ready asserted.
    localparam uflc_cfg_s CFG_RST = 7'h51;

    typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_TRAIL} uflc_tx_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uflc_rx_e;

    // One received character with its error flags; done is a one-cycle pulse.
    typedef struct packed {
        logic       done;
        logic       ferr;
        logic       perr;
        logic [7:0] data;
    } uflc_rxres_s;

    typedef struct packed {
        uflc_rx_e          st;
        logic [DIV_W-1:0]  cnt;
        logic [2:0]        idx;
        logic [7:0]        sh;
        logic              par;
        logic              q;
        uflc_rxres_s       res;
    } uflc_rxst_s;

    typedef struct packed {
        uflc_cfg_s         cfg;
        logic [DIV_W-1:0]  div;
        uflc_tx_e          tst;
        logic [DIV_W-1:0]  cnt;
        logic [2:0]        idx;
        logic              stopn;
        logic [7:0]        sh;
        logic              par;
        logic              pend;
        logic              txd;
        logic              txact;
        logic              rts_n;
        logic              dtr_n;
        logic              wake;
        logic              ri_q;
        logic [EV_W-1:0]   evt;
        logic [EV_W-1:0]   mask;
        logic [7:0]        rxbuf;
        logic              rxfull;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        logic              irq;
    } uflc_top_s;

endpackage

// File: hdl/uflc_rx.sv
// Receiver of the serial port: finds the start edge and samples each bit mid-period.
// Assumes the serial input is already synchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none

module uflc_rx (
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    input  wire logic                  rxd,
    input  wire logic [17:0]           div_m1,
    input  wire uflc_pkg::uflc_cfg_s   cfg,
    output var  uflc_pkg::uflc_rxres_s res
);

    uflc_pkg::uflc_rxst_s s;
    uflc_pkg::uflc_rxst_s n;
    logic                 tick;
    logic [2:0]           last;
    logic [7:0]           dat;

    ////////////////////////////////////////////////////////////////////////////
    // Next state; a seven-bit character sits in the top of the shifter.
    always_comb
    begin
        n          = s;
        n.res.done = 1'b0;
        n.q        = rxd;
        tick       = (s.cnt == '0);
        last       = cfg.data8 ? 3'h7 : 3'h6;
        dat        = cfg.data8 ? s.sh : {1'b0, s.sh[7:1]};
        if (!tick)
        begin
            n.cnt = s.cnt - 18'h00001;
        end
        case (s.st)
            uflc_pkg::RX_IDLE:
            begin
                // Only a high-to-low edge opens a frame, so a stuck-low line waits.
                if (s.q && !rxd)
                begin
                    n.st  = uflc_pkg::RX_START;
                    n.cnt = {1'b0, div_m1[17:1]};
                end
            end
            uflc_pkg::RX_START:
            begin
                if (tick)
                begin
                    n.cnt = div_m1;
                    n.idx = 3'h0;
                    n.st  = rxd ? uflc_pkg::RX_IDLE : uflc_pkg::RX_DATA;
                end
            end
            uflc_pkg::RX_DATA:
            begin
                if (tick)
                begin
                    n.cnt = div_m1;
                    n.sh  = {rxd, s.sh[7:1]};
                    n.idx = s.idx + 3'h1;
                    if (s.idx == last)
                    begin
                        n.st = cfg.par_en ? uflc_pkg::RX_PAR : uflc_pkg::RX_STOP;
                    end
                end
            end
            uflc_pkg::RX_PAR:
            begin
                if (tick)
                begin
                    n.cnt = div_m1;
                    n.par = rxd;
                    n.st  = uflc_pkg::RX_STOP;
                end
            end
            uflc_pkg::RX_STOP:
            begin
                // Back to idle at mid stop bit so a following start edge is caught.
                if (tick)
                begin
                    n.st       = uflc_pkg::RX_IDLE;
                    n.res.done = 1'b1;
                    n.res.data = dat;
                    n.res.ferr = !rxd;
                    n.res.perr = cfg.par_en && (s.par != (^dat ^ cfg.par_odd));
                end
            end
            default:
            begin
                n.st = uflc_pkg::RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s   <= '0;
            s.q <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    assign res = s.res;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the receive sequence.
    default clocking rx_cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence start_edge;
        (s.st == uflc_pkg::RX_IDLE) && s.q && !rxd;
    endsequence

    a_half_bit_wait: assert property (start_edge |=> (s.st == uflc_pkg::RX_START) [*3])
        else $error("Start bit sampled before its middle.");
    a_false_start: assert property ((s.st == uflc_pkg::RX_START) && tick && rxd |=> s.st == uflc_pkg::RX_IDLE)
        else $error("High start bit did not abandon the frame.");
    a_stop_check: assert property ((s.st == uflc_pkg::RX_STOP) && tick |=> res.done && (res.ferr == !$past(rxd)))
        else $error("Stop bit not checked.");
    a_idle_hold: assert property ((s.st == uflc_pkg::RX_IDLE) && !(s.q && !rxd) |=> s.st == uflc_pkg::RX_IDLE)
        else $error("Receiver left idle without a falling edge.");

endmodule

`default_nettype wire

// File: hdl/uflc_top.sv
// Flow-controlled asynchronous serial port with an APB register file.
// Assumes all pin inputs are synchronous to core_clk and the APB master follows the standard protocol.
//
// Contract
// - Bit rate programmable from 183 baud up to 5 Mbaud.
// - Fastest bit lasts eight core clocks; clock over eight is the top rate.
// - Frame is start, seven or eight data, optional parity, one or two stops.
// - Data bits go least significant first.
// - Reset gives 9600 baud, handshake flow control, eight bits, no parity, one stop.
// - Rate, flow control, width, parity and stops are writable at run time.
// - Driver enable rises a bit before start, falls a bit after the last bit.
// - Driver enable can steer an RS485 line driver directly.
// - Frames leave on the serial output and arrive on the serial input.
// - Active-low request-to-send tells the far end whether it may send.
// - Active-low terminal-ready output follows the terminal-ready bit that software writes to the configuration.
// - Ring indicator low wakes the device when software enabled it.
`timescale 1ns/10ps
`default_nettype none

module uflc_top #(
    parameter logic [17:0] RST_DIV = 18'(uflc_pkg::DIV_RST)
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             tx_serial_out,
    input  wire logic        rx_serial_in,
    output logic             rts_n,
    input  wire logic        cts_n,
    output logic             dtr_n,
    input  wire logic        dcd_n,
    input  wire logic        ring_indicator_n,
    output logic             tx_active,
    output logic             irq,
    output logic             wake
);

    uflc_pkg::uflc_top_s   s;
    uflc_pkg::uflc_top_s   n;
    uflc_pkg::uflc_rxres_s rx_res;
    logic [17:0]           ediv_m1;
    logic                  tick;
    logic                  busy;
    logic                  setup;
    logic                  acc;
    logic                  rd_rx;
    logic [2:0]            last;
    logic [5:0]            set_ev;
    logic [5:0]            clr_ev;

    ////////////////////////////////////////////////////////////////////////////
    // Bit timing: a divisor below the floor is raised to it rather than refused.
    assign ediv_m1 = (s.div < uflc_pkg::DIV_MIN) ? uflc_pkg::DIV_MIN - 18'h00001 : s.div - 18'h00001;
    assign tick    = (s.cnt == '0);

    // Receiver shares the live configuration and divisor with the transmitter.
    uflc_rx u_rx (
        .core_clk (core_clk),
        .rstn     (rstn),
        .rxd      (rx_serial_in),
        .div_m1   (ediv_m1),
        .cfg      (s.cfg),
        .res      (rx_res)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the transmitter, register file and modem lines.
    always_comb
    begin
        n      = s;
        set_ev = '0;
        clr_ev = '0;
        rd_rx  = 1'b0;
        busy   = s.pend || (s.tst != uflc_pkg::TX_IDLE);
        setup  = psel && !penable;
        acc    = psel && penable && s.pready;
        last   = s.cfg.data8 ? 3'h7 : 3'h6;
        if (!tick)
        begin
            n.cnt = s.cnt - 18'h00001;
        end

        // Transmit sequence; lead, start, parity and trail states each last one bit period.
        case (s.tst)
            uflc_pkg::TX_IDLE:
            begin
                // Flow control only holds back the start of a frame.
                if (s.pend && (!s.cfg.flow || !cts_n))
                begin
                    n.tst   = uflc_pkg::TX_LEAD;
                    n.pend  = 1'b0;
                    n.txact = 1'b1;
                    n.cnt   = ediv_m1;
                end
            end
            uflc_pkg::TX_LEAD:
            begin
                if (tick)
                begin
                    n.tst = uflc_pkg::TX_START;
                    n.txd = 1'b0;
                    n.cnt = ediv_m1;
                end
            end
            uflc_pkg::TX_START:
            begin
                if (tick)
                begin
                    n.tst = uflc_pkg::TX_DATA;
                    n.txd = s.sh[0];
                    n.idx = 3'h0;
                    n.cnt = ediv_m1;
                end
            end
            uflc_pkg::TX_DATA:
            begin
                if (tick)
                begin
                    n.cnt = ediv_m1;
                    n.sh  = s.sh >> 1;
                    if (s.idx != last)
                    begin
                        n.idx = s.idx + 3'h1;
                        n.txd = s.sh[1];
                    end
                    else if (s.cfg.par_en)
                    begin
                        n.tst = uflc_pkg::TX_PAR;
                        n.txd = s.par;
                    end
                    else
                    begin
                        n.tst   = uflc_pkg::TX_STOP;
                        n.txd   = 1'b1;
                        n.stopn = s.cfg.stop2;
                    end
                end
            end
            uflc_pkg::TX_PAR:
            begin
                if (tick)
                begin
                    n.tst   = uflc_pkg::TX_STOP;
                    n.txd   = 1'b1;
                    n.stopn = s.cfg.stop2;
                    n.cnt   = ediv_m1;
                end
            end
            uflc_pkg::TX_STOP:
            begin
                // A second stop bit reloads the counter once more.
                if (tick)
                begin
                    n.cnt   = ediv_m1;
                    n.stopn = 1'b0;
                    if (!s.stopn)
                    begin
                        n.tst = uflc_pkg::TX_TRAIL;
                    end
                end
            end
            uflc_pkg::TX_TRAIL:
            begin
                // The driver stays enabled for one idle bit after the last stop.
                if (tick)
                begin
                    n.tst   = uflc_pkg::TX_IDLE;
                    n.txact = 1'b0;
                    set_ev[uflc_pkg::EV_TXDONE] = 1'b1;
                end
            end
            default:
            begin
                n.tst   = uflc_pkg::TX_IDLE;
                n.txd   = 1'b1;
                n.txact = 1'b0;
            end
        endcase

        // APB read data and error are prepared in the setup cycle.
        n.pready  = setup;
        n.pslverr = 1'b0;
        n.prdata  = '0;
        if (setup)
        begin
            case (paddr)
                uflc_pkg::A_CFG:  n.prdata = 32'(s.cfg);
                uflc_pkg::A_DIV:  n.prdata = 32'(s.div);
                uflc_pkg::A_TXD:  n.prdata = '0;
                uflc_pkg::A_RXD:  n.prdata = 32'(s.rxbuf);
                uflc_pkg::A_STAT: n.prdata = 32'(s.evt);
                uflc_pkg::A_MASK: n.prdata = 32'(s.mask);
                uflc_pkg::A_LINE: n.prdata = 32'({s.rxfull, ~ring_indicator_n, ~dcd_n, ~cts_n, busy});
                default:          n.pslverr = 1'b1;
            endcase
        end

        // Writes and read side effects land on the completing access edge.
        if (acc && pwrite)
        begin
            case (paddr)
                uflc_pkg::A_CFG:  n.cfg  = uflc_pkg::uflc_cfg_s'(pwdata[6:0]);
                uflc_pkg::A_DIV:  n.div  = pwdata[17:0];
                uflc_pkg::A_STAT: clr_ev = pwdata[5:0];
                uflc_pkg::A_MASK: n.mask = pwdata[5:0];
                uflc_pkg::A_TXD:
                begin
                    // No buffer: a character written while busy is dropped.
                    if (!busy)
                    begin
                        n.sh   = s.cfg.data8 ? pwdata[7:0] : {1'b0, pwdata[6:0]};
                        n.par  = ^pwdata[6:0] ^ (s.cfg.data8 & pwdata[7]) ^ s.cfg.par_odd;
                        n.pend = 1'b1;
                    end
                end
                default:
                begin
                    n.mask = s.mask;
                end
            endcase
        end
        if (acc && !pwrite && (paddr == uflc_pkg::A_RXD))
        begin
            rd_rx = 1'b1;
        end

        // Received character; a new one wins over a read in the same cycle.
        if (rx_res.done)
        begin
            n.rxbuf                   = rx_res.data;
            set_ev[uflc_pkg::EV_RXRDY] = 1'b1;
            set_ev[uflc_pkg::EV_FERR]  = rx_res.ferr;
            set_ev[uflc_pkg::EV_PERR]  = rx_res.perr;
            set_ev[uflc_pkg::EV_OVR]   = s.rxfull && !rd_rx;
        end
        n.rxfull = (s.rxfull && !rd_rx) || rx_res.done;

        // Ring indicator falling edge is an event of its own.
        n.ri_q = ring_indicator_n;
        set_ev[uflc_pkg::EV_RING] = s.ri_q && !ring_indicator_n;

        // Sticky events: a set in the clearing cycle survives the clear.
        n.evt = (s.evt & ~clr_ev) | set_ev;
        n.irq = |(n.evt & n.mask);

        // Modem outputs follow the configuration written this cycle.
        n.rts_n = n.cfg.flow ? n.rxfull : 1'b0;
        n.dtr_n = !n.cfg.dtr;
        n.wake  = n.cfg.ri_wake && !ring_indicator_n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register with reset defaults.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s       <= '0;
            s.cfg   <= uflc_pkg::CFG_RST;
            s.div   <= RST_DIV;
            s.txd   <= 1'b1;
            s.dtr_n <= 1'b0;
            s.ri_q  <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    // Every output comes straight from the state register.
    assign prdata        = s.prdata;
    assign pready        = s.pready;
    assign pslverr       = s.pslverr;
    assign tx_serial_out = s.txd;
    assign tx_active     = s.txact;
    assign rts_n         = s.rts_n;
    assign dtr_n         = s.dtr_n;
    assign irq           = s.irq;
    assign wake          = s.wake;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the transmit sequence and modem lines.
    default clocking tx_cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence lead_done;
        (s.tst == uflc_pkg::TX_LEAD) && tick;
    endsequence

    sequence start_low;
        !tx_serial_out [*8];
    endsequence

    a_lead_start: assert property (lead_done |=> start_low)
        else $error("Start bit shorter than eight clocks.");
    a_lead_high: assert property ($rose(tx_active) |-> tx_serial_out [*8])
        else $error("Driver enabled less than a bit before start.");
    a_cts_gate: assert property ((s.tst == uflc_pkg::TX_IDLE) && (n.tst == uflc_pkg::TX_LEAD) |-> (!s.cfg.flow || !cts_n))
        else $error("Frame started while clear-to-send was off.");
    a_frame_finish: assert property ((s.tst == uflc_pkg::TX_STOP) && !tick |=> s.tst == uflc_pkg::TX_STOP)
        else $error("Frame cut short.");
    a_idle_line: assert property ((s.tst == uflc_pkg::TX_IDLE) |-> tx_serial_out && !tx_active)
        else $error("Idle line not high or driver left on.");
    a_lsb_first: assert property ((s.tst == uflc_pkg::TX_START) && tick |=> tx_serial_out == $past(s.sh[0]))
        else $error("First data bit is not the least significant.");
    a_drv_enable: assert property ((s.tst inside {uflc_pkg::TX_START, uflc_pkg::TX_DATA, uflc_pkg::TX_STOP}) |-> tx_active)
        else $error("Driver off during a frame.");
    a_rts_full: assert property (rx_res.done && s.cfg.flow && !psel |=> rts_n)
        else $error("Request-to-send stayed on with a full buffer.");
    a_wake_ring: assert property (s.cfg.ri_wake && !ring_indicator_n && !psel |=> wake)
        else $error("Ring did not wake.");
    a_rx_sticky: assert property (rx_res.done |=> s.evt[uflc_pkg::EV_RXRDY])
        else $error("Receive event lost.");

endmodule

`default_nettype wire

// File: tb/uflc_far_end.sv
// Far-end terminal: sends frames into the port and captures frames it sends.
// Assumes a bit period of D core clocks and a shared core_clk.
`timescale 1ns/10ps
`default_nettype none
module uflc_far_end #(
    parameter int D = 8
) (
    input  wire logic core_clk,
    input  wire logic tx_serial_out,
    input  wire logic tx_active,
    output logic      rx_serial_in
);
    int i;
    // The line idles high between frames, as a pulled-up line would.
    initial rx_serial_in = 1'b1;
    // Start low, data least significant first, one stop of the given level.
    task send(input logic [7:0] b, input logic stop);
        for (i = 0; i < 10; i++)
        begin
            @(posedge core_clk);
            rx_serial_in <= (i == 0) ? 1'b0 : (i == 9) ? stop : b[i-1];
            repeat (D - 1) @(posedge core_clk);
        end
        @(posedge core_clk);
        rx_serial_in <= 1'b1;
        repeat (D) @(posedge core_clk);
    endtask
    // Samples on the falling edge so the port's outputs have settled.
    task grab(output logic [7:0] d, output logic stp, output int lead, output int trail);
        for (i = 0; i < 500 && tx_active !== 1'b1; i++) @(negedge core_clk);
        for (lead = 0; lead < 500 && tx_serial_out !== 1'b0; lead++) @(negedge core_clk);
        repeat (D / 2) @(negedge core_clk);
        for (i = 0; i < 8; i++)
        begin
            repeat (D) @(negedge core_clk);
            d[i] = tx_serial_out;
        end
        repeat (D) @(negedge core_clk);
        stp = tx_serial_out;
        for (trail = 0; trail < 500 && tx_active !== 1'b0; trail++) @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

// File: tb/uflc_tb_top.sv
// Self-checking bench of the serial port over APB with a far-end model.
// Assumes RST_DIV of 8, so a bit is eight core clocks.
`timescale 1ns/10ps
`default_nettype none
module uflc_tb_top;
    logic        core_clk, rstn, psel, penable, pwrite, cts_n, dcd_n, ring_indicator_n;
    logic [7:0]  paddr, d;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, tx_serial_out, rx_serial_in, rts_n, dtr_n, tx_active, irq, wake, e, stp;
    int          n_errors, num_checks, i, lead, trail;
    uflc_top #(.RST_DIV(18'h00008)) DUT (.core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_serial_out(tx_serial_out), .rx_serial_in(rx_serial_in), .rts_n(rts_n),
        .cts_n(cts_n), .dtr_n(dtr_n), .dcd_n(dcd_n), .ring_indicator_n(ring_indicator_n),
        .tx_active(tx_active), .irq(irq), .wake(wake));
    uflc_far_end #(.D(8)) far (.core_clk(core_clk), .tx_serial_out(tx_serial_out),
        .tx_active(tx_active), .rx_serial_in(rx_serial_in));
    // A 40 MHz clock.
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task end_sim;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask
    // One APB transfer; the request holds until pready is seen at an edge.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        if (i == 20)
        begin
            n_errors++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cts_n, dcd_n, ring_indicator_n} = 3'b011;
        n_errors = 0;
        num_checks = 0;
        rstn = 1'b0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        chk({dtr_n, rts_n, tx_serial_out}, 3'b001);
        xfer(1'b0, uflc_pkg::A_CFG, 0); chk(r, 32'h51);
        xfer(1'b0, uflc_pkg::A_DIV, 0); chk(r, 32'h8);
        xfer(1'b0, 8'h1c, 0); chk(e, 1'b1);
        xfer(1'b1, uflc_pkg::A_MASK, 32'h3f);
        fork
            far.grab(d, stp, lead, trail);
            xfer(1'b1, uflc_pkg::A_TXD, 32'ha5);
        join
        chk(d, 8'ha5);
        chk(stp, 1'b1);
        chk(lead, 8);
        chk(trail, 12);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b1);
        xfer(1'b1, uflc_pkg::A_STAT, 32'h3f);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b0);
        cts_n <= 1'b1;
        xfer(1'b1, uflc_pkg::A_TXD, 32'h5a);
        repeat (40) @(posedge core_clk);
        chk(tx_active, 1'b0);
        fork
            far.grab(d, stp, lead, trail);
            cts_n <= 1'b0;
        join
        chk(d, 8'h5a);
        far.send(8'h3c, 1'b1);
        chk(rts_n, 1'b1);
        xfer(1'b0, uflc_pkg::A_RXD, 0); chk(r, 32'h3c);
        xfer(1'b0, uflc_pkg::A_STAT, 0); chk(r[1], 1'b1);
        far.send(8'h11, 1'b0);
        xfer(1'b0, uflc_pkg::A_STAT, 0); chk(r[2], 1'b1);
        xfer(1'b1, uflc_pkg::A_DIV, 32'h355d3);
        xfer(1'b0, uflc_pkg::A_DIV, 0); chk(r, 32'h355d3);
        xfer(1'b1, uflc_pkg::A_DIV, 32'h8);
        // Seven data bits, even parity, terminal ready off: the frame's top byte bit is the parity bit.
        xfer(1'b1, uflc_pkg::A_CFG, 32'h12);
        @(negedge core_clk);
        chk(dtr_n, 1'b1);
        far.send(8'h81, 1'b1);
        xfer(1'b0, uflc_pkg::A_RXD, 0); chk(r, 32'h01);
        xfer(1'b0, uflc_pkg::A_STAT, 0); chk(r[3], 1'b0);
        far.send(8'h01, 1'b1);
        xfer(1'b0, uflc_pkg::A_STAT, 0); chk(r[3], 1'b1);
        fork
            far.grab(d, stp, lead, trail);
            xfer(1'b1, uflc_pkg::A_TXD, 32'h07);
        join
        chk(d, 8'h87);
        xfer(1'b1, uflc_pkg::A_MASK, 0);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b0);
        dcd_n <= 1'b0;
        xfer(1'b0, uflc_pkg::A_LINE, 0); chk(r[2], 1'b1);
        xfer(1'b1, uflc_pkg::A_CFG, 32'h71);
        ring_indicator_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(wake, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
